// [bench/cmd_host_model.sv]
// command decoder model feeding the checker's command port
`timescale 1ns/100ps
module cmd_host_model import fwp_pkg::*; (
  input wire logic clk,
  input wire logic go,
  input wire cmd_kind_t kind,
  input wire logic [26:0] addr,
  input wire logic [15:0] count,
  input wire logic [7:0] data,
  input wire logic [7:0] old,
  input wire logic pinLow,
  output logic cmdValid,
  output cmd_kind_t cmdKind,
  output logic [26:0] cmdAddr,
  output logic [15:0] cmdClkCount,
  output logic [7:0] cmdData,
  output logic [7:0] oldData,
  output logic writeProtect_n
);
  initial begin
    cmdValid = 1'b0;
    cmdKind = KIND_WRDI;
    cmdAddr = 27'h0;
    cmdClkCount = 16'h0;
    cmdData = 8'h0;
    oldData = 8'h0;
    writeProtect_n = 1'b1;
  end
  always @(posedge clk) begin
    cmdValid <= go;
    writeProtect_n <= !pinLow;
    if (go) begin
      cmdKind <= kind;
      cmdAddr <= addr;
      cmdClkCount <= count;
      cmdData <= data;
      oldData <= old;
    end else begin
      // idle fields scrambled so stale values cannot be relied on
      cmdKind <= cmd_kind_t'(~cmdKind);
      cmdAddr <= ~cmdAddr;
      cmdClkCount <= ~cmdClkCount;
      cmdData <= ~cmdData;
      oldData <= ~oldData;
    end
  end
endmodule

// [bench/flash_write_protection_checker_tb_top.sv]
// testbench for the flash write protection checker
`timescale 1ns/100ps
module flash_write_protection_checker_tb_top import fwp_pkg::*;;
  typedef struct {
    logic g;
    cause_t c;
    logic [26:0] ea;
    logic [7:0] d;
    logic [26:0] ca;
  } exp_t;
  exp_t q[$];
  exp_t e;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, data, old, cmdData, oldData, respData;
  logic [31:0] pwdata, prdata, rd;
  logic go, pinLow, cmdValid, writeProtect_n, er;
  logic respValid, respGrant, respSegment;
  cmd_kind_t kind, cmdKind;
  cause_t respCause;
  logic [26:0] addr, cmdAddr, respAddr;
  logic [15:0] count, cmdClkCount;
  logic [1:0] respDie;
  int n_errors, checks, seed;

  cmd_host_model host (.clk(clk), .go(go), .kind(kind), .addr(addr), .count(count),
    .data(data), .old(old), .pinLow(pinLow), .cmdValid(cmdValid), .cmdKind(cmdKind),
    .cmdAddr(cmdAddr), .cmdClkCount(cmdClkCount), .cmdData(cmdData), .oldData(oldData),
    .writeProtect_n(writeProtect_n));

  flash_write_protection_checker uut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .writeProtect_n(writeProtect_n),
    .cmdValid(cmdValid), .cmdKind(cmdKind), .cmdAddr(cmdAddr), .cmdClkCount(cmdClkCount),
    .cmdData(cmdData), .oldData(oldData), .respValid(respValid), .respGrant(respGrant),
    .respCause(respCause), .respAddr(respAddr), .respData(respData), .respDie(respDie),
    .respSegment(respSegment));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle cycle so a following call never reassigns psel in the same step
    @(posedge clk);
    if (i == 20) begin
      n_errors++;
      complete_run();
    end
  endtask

  task automatic cmd(input cmd_kind_t k, input logic [26:0] a, input logic [15:0] n,
      input logic [7:0] d, input logic g, input cause_t c, input logic [26:0] ea);
    logic [7:0] o;
    o = $random(seed);
    go <= 1'b1;
    kind <= k;
    addr <= a;
    count <= n;
    data <= d;
    old <= o;
    if (k != KIND_WREN && k != KIND_WRDI) q.push_back('{g, c, ea, o & d, a});
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // enable first, then the modifying command with a whole-byte clock count
  task automatic w(input cmd_kind_t k, input logic [26:0] a, input logic [7:0] d,
      input logic g, input cause_t c, input logic [26:0] ea);
    cmd(KIND_WREN, 27'h0, 16'h0008, 8'h00, 1'b0, CAUSE_NONE, 27'h0);
    cmd(k, a, 16'h0020, d, g, c, ea);
  endtask

  always @(negedge clk) begin
    if (respValid === 1'b1) begin
      if (q.size() == 0) chk("respValid", 1'b1, 1'b0);
      else begin
        e = q.pop_front();
        chk("respGrant", respGrant, e.g);
        chk("respCause", respCause, e.c);
        chk("respData", respData, e.d);
        chk("respDie", respDie, e.ca[26:25]);
        chk("respSegment", respSegment, e.ca[24]);
        if (e.g) chk("respAddr", respAddr, e.ea);
      end
    end
  end

  initial begin
    int n, t, k, s, b, sz;
    logic p;
    logic [26:0] a;
    seed = 32'h8116;
    n_errors = 0;
    checks = 0;
    sys_rst = 1'b1;
    {psel, penable, pwrite, go, pinLow} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    kind = KIND_WREN;
    addr = 27'h0;
    count = 16'h0;
    data = 8'h00;
    old = 8'h00;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    w(KIND_PROGRAM, 27'h10, 8'h0F, 1'b0, CAUSE_POR, 27'h0);
    repeat (45) @(posedge clk);
    apb(1'b0, 8'h04, 32'h0);
    chk("status", rd[8:0], 9'h002);
    // a refused command leaves the latch set, so clear it before the latch test
    cmd(KIND_WRDI, 27'h0, 16'h0008, 8'h00, 1'b0, CAUSE_NONE, 27'h0);
    cmd(KIND_PROGRAM, 27'h20, 16'h000D, 8'h00, 1'b0, CAUSE_CLKCNT, 27'h0);
    cmd(KIND_PROGRAM, 27'h20, 16'h0010, 8'h00, 1'b0, CAUSE_WEL, 27'h0);
    for (k = 0; k < 4; k++) begin
      a = $random(seed);
      w(KIND_PROGRAM, a, $random(seed), 1'b1, CAUSE_NONE, a);
      w(KIND_ERASE_SUB, a, 8'hFF, 1'b1, CAUSE_NONE, a & 27'h7FFF000);
      w(KIND_ERASE_SECT, a, 8'hFF, 1'b1, CAUSE_NONE, a & 27'h7FF0000);
      w(KIND_ERASE_DIE, a, 8'hFF, 1'b1, CAUSE_NONE, a & 27'h6000000);
    end
    for (n = 0; n < 16; n++) begin
      for (t = 0; t < 2; t++) begin
        w(KIND_STATUS_WRITE, 27'h0, {3'h0, t[0], n[3:0]}, 1'b1, CAUSE_NONE, 27'h0);
        sz = (n > 11) ? 2048 : (n == 0) ? 0 : 1 << (n - 1);
        b = t ? sz : 2048 - sz;
        for (k = -1; k < 1; k++) begin
          s = (b + k) & 2047;
          p = t ? (s < sz) : (s >= 2048 - sz);
          w(KIND_ERASE_SECT, {s[10:0], 16'h1234}, 8'hFF, !p, p ? CAUSE_RANGE : CAUSE_NONE,
            {s[10:0], 16'h0});
        end
      end
    end
    w(KIND_STATUS_WRITE, 27'h0, 8'h01, 1'b1, CAUSE_NONE, 27'h0);
    w(KIND_ERASE_DIE, 27'h6000000, 8'hFF, 1'b0, CAUSE_RANGE, 27'h0);
    w(KIND_STATUS_WRITE, 27'h0, 8'h00, 1'b1, CAUSE_NONE, 27'h0);
    a = 27'h0050000;
    w(KIND_LOCK_WRITE, a, 8'h01, 1'b1, CAUSE_NONE, a);
    apb(1'b1, 8'h00, 32'h0000_0500);
    apb(1'b0, 8'h08, 32'h0);
    chk("lockView", rd[1:0], 2'h1);
    w(KIND_PROGRAM, a + 7, 8'h3C, 1'b0, CAUSE_LOCK, a);
    w(KIND_ERASE_DIE, 27'h0, 8'hFF, 1'b0, CAUSE_LOCK, 27'h0);
    w(KIND_LOCK_WRITE, a, 8'h00, 1'b1, CAUSE_NONE, a);
    w(KIND_PROGRAM, a, 8'h3C, 1'b1, CAUSE_NONE, a);
    w(KIND_LOCK_WRITE, a, 8'h03, 1'b1, CAUSE_NONE, a);
    apb(1'b0, 8'h08, 32'h0);
    chk("lockView", rd[1:0], 2'h3);
    w(KIND_LOCK_WRITE, a, 8'h00, 1'b0, CAUSE_LOCKDOWN, a);
    w(KIND_PROGRAM, a, 8'h3C, 1'b0, CAUSE_LOCK, a);
    w(KIND_OTP_PROG, a, 8'h5A, 1'b1, CAUSE_NONE, a);
    // a reset in mid-run is the only way out of lock-down
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (45) @(posedge clk);
    apb(1'b1, 8'h00, 32'h0000_0500);
    apb(1'b0, 8'h08, 32'h0);
    chk("lockView", rd[1:0], 2'h0);
    w(KIND_PROGRAM, a, 8'h3C, 1'b1, CAUSE_NONE, a);
    pinLow <= 1'b1;
    repeat (4) @(posedge clk);
    w(KIND_STATUS_WRITE, 27'h0, 8'h01, 1'b0, CAUSE_PIN, 27'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk("pinLow", rd[7], 1'b1);
    apb(1'b1, 8'h00, 32'h0000_0001);
    w(KIND_STATUS_WRITE, 27'h0, 8'h00, 1'b1, CAUSE_NONE, 27'h0);
    pinLow <= 1'b0;
    apb(1'b0, 8'h10, 32'h0);
    chk("pslverr", er, 1'b1);
    chk("prdata", rd, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk("count", rd, 32'h0001_0002);
    chk("pslverr", er, 1'b0);
    chk("pending", q.size(), 0);
    complete_run();
  end
endmodule

// [design/flash_write_protection_checker.sv]
// grant/refuse checker for program, erase and register-write requests
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "fwp_map.svh"
module flash_write_protection_checker import fwp_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic writeProtect_n,
  input wire logic cmdValid,
  input wire cmd_kind_t cmdKind,
  input wire logic [26:0] cmdAddr,
  input wire logic [15:0] cmdClkCount,
  input wire logic [7:0] cmdData,
  input wire logic [7:0] oldData,
  output logic respValid,
  output logic respGrant,
  output cause_t respCause,
  output logic [26:0] respAddr,
  output logic [7:0] respData,
  output logic [1:0] respDie,
  output logic respSegment
);
  localparam int PorCycles = `FWP_POR_CYCLES;

  function automatic logic isModifying(input cmd_kind_t k);
    return !(k == KIND_WREN || k == KIND_WRDI);
  endfunction

  // pin synchroniser
  logic wpSync1_ff, wpSync2_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wpSync1_ff <= 1'b1;
      wpSync2_ff <= 1'b1;
    end else begin
      wpSync1_ff <= writeProtect_n;
      wpSync2_ff <= wpSync1_ff;
    end
  end

  // power-on hold timer
  por_state_t porState_ff, nxt_porState;
  logic [15:0] porCnt_ff, nxt_porCnt;
  always_comb begin
    nxt_porState = porState_ff;
    nxt_porCnt = porCnt_ff;
    unique case (porState_ff)
      POR_HOLD: begin
        nxt_porCnt = porCnt_ff + 16'h0001;
        if (porCnt_ff == 16'(PorCycles - 1)) begin
          nxt_porState = POR_DONE;
        end
      end
      POR_DONE: nxt_porCnt = porCnt_ff;
    endcase
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      porState_ff <= POR_HOLD;
      porCnt_ff <= 16'h0000;
    end else begin
      porState_ff <= nxt_porState;
      porCnt_ff <= nxt_porCnt;
    end
  end
  logic porBusy;
  assign porBusy = (porState_ff == POR_HOLD);

  // status, lock arrays and protect decode
  logic wel_ff, nxt_wel;
  logic [3:0] protectCode_ff, nxt_protectCode;
  logic topBottom_ff, nxt_topBottom;
  logic [2047:0] lockBits_ff;
  logic [2047:0] downBits_ff;
  logic quad_ff;
  logic [10:0] viewSector_ff;
  logic anyProt;
  logic [10:0] protLo, protHi;

  protect_range_decode rangeDecode (
    .protectCode(protectCode_ff),
    .topBottom(topBottom_ff),
    .anyProt(anyProt),
    .protLo(protLo),
    .protHi(protHi)
  );

  logic [3:0] dieLocked;
  genvar d;
  generate
    for (d = 0; d < 4; d++) begin : g_die
      assign dieLocked[d] = |lockBits_ff[d * 512 +: 512];
    end
  endgenerate

  logic [10:0] sector;
  logic [1:0] die;
  logic [10:0] dieLo, dieHi;
  logic inRange, dieInRange, pinFreeze;
  assign sector = cmdAddr[26:16];
  assign die = cmdAddr[26:25];
  assign dieLo = {die, 9'h000};
  assign dieHi = {die, 9'h1FF};
  assign inRange = anyProt && sector >= protLo && sector <= protHi;
  assign dieInRange = anyProt && protLo <= dieHi && protHi >= dieLo;
  assign pinFreeze = !quad_ff && !wpSync2_ff;

  // command check
  logic respValid_ff, nxt_respValid;
  logic respGrant_ff, nxt_respGrant;
  cause_t respCause_ff, nxt_respCause;
  logic [26:0] respAddr_ff, nxt_respAddr;
  logic [7:0] respData_ff, nxt_respData;
  logic [1:0] respDie_ff, nxt_respDie;
  logic respSegment_ff, nxt_respSegment;
  logic lockWrEn;
  logic [15:0] grantCnt_ff, nxt_grantCnt, refuseCnt_ff, nxt_refuseCnt;

  always_comb begin
    nxt_respValid = 1'b0;
    nxt_respGrant = 1'b0;
    nxt_respCause = respCause_ff;
    nxt_respAddr = respAddr_ff;
    nxt_respData = respData_ff;
    nxt_respDie = respDie_ff;
    nxt_respSegment = respSegment_ff;
    nxt_wel = wel_ff;
    nxt_protectCode = protectCode_ff;
    nxt_topBottom = topBottom_ff;
    nxt_grantCnt = grantCnt_ff;
    nxt_refuseCnt = refuseCnt_ff;
    lockWrEn = 1'b0;
    if (cmdValid && !isModifying(cmdKind)) begin
      nxt_wel = (cmdKind == KIND_WREN);
    end else if (cmdValid) begin
      nxt_respValid = 1'b1;
      nxt_respDie = die;
      nxt_respSegment = cmdAddr[24];
      nxt_respCause = CAUSE_NONE;
      if (porBusy) begin
        nxt_respCause = CAUSE_POR;
      end else if (cmdClkCount[2:0] != 3'h0) begin
        nxt_respCause = CAUSE_CLKCNT;
      end else if (!wel_ff) begin
        nxt_respCause = CAUSE_WEL;
      end else begin
        unique case (cmdKind)
          KIND_PROGRAM, KIND_ERASE_SUB, KIND_ERASE_SECT: begin
            if (lockBits_ff[sector]) begin
              nxt_respCause = CAUSE_LOCK;
            end else if (inRange) begin
              nxt_respCause = CAUSE_RANGE;
            end
          end
          KIND_ERASE_DIE: begin
            if (dieLocked[die]) begin
              nxt_respCause = CAUSE_LOCK;
            end else if (dieInRange) begin
              nxt_respCause = CAUSE_RANGE;
            end
          end
          KIND_LOCK_WRITE: begin
            if (downBits_ff[sector]) begin
              nxt_respCause = CAUSE_LOCKDOWN;
            end
          end
          KIND_STATUS_WRITE: begin
            if (pinFreeze) begin
              nxt_respCause = CAUSE_PIN;
            end
          end
          default: nxt_respCause = CAUSE_NONE;
        endcase
      end
      nxt_respGrant = (nxt_respCause == CAUSE_NONE);
      // erase boundaries from the address, full address for the rest
      unique case (cmdKind)
        KIND_ERASE_SUB: nxt_respAddr = {cmdAddr[26:12], 12'h000};
        KIND_ERASE_SECT: nxt_respAddr = {cmdAddr[26:16], 16'h0000};
        KIND_ERASE_DIE: nxt_respAddr = {cmdAddr[26:25], 25'h0000000};
        default: nxt_respAddr = cmdAddr;
      endcase
      nxt_respData = oldData & cmdData;
      if (nxt_respGrant) begin
        nxt_wel = 1'b0;
        nxt_grantCnt = grantCnt_ff + 16'h0001;
        lockWrEn = (cmdKind == KIND_LOCK_WRITE);
        if (cmdKind == KIND_STATUS_WRITE) begin
          nxt_protectCode = cmdData[3:0];
          nxt_topBottom = cmdData[4];
        end
      end else begin
        nxt_refuseCnt = refuseCnt_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      respValid_ff <= 1'b0;
      respGrant_ff <= 1'b0;
      respCause_ff <= CAUSE_NONE;
      respAddr_ff <= 27'h0000000;
      respData_ff <= 8'hFF;
      respDie_ff <= 2'h0;
      respSegment_ff <= 1'b0;
      wel_ff <= 1'b0;
      protectCode_ff <= 4'h0;
      topBottom_ff <= 1'b0;
      grantCnt_ff <= 16'h0000;
      refuseCnt_ff <= 16'h0000;
    end else begin
      respValid_ff <= nxt_respValid;
      respGrant_ff <= nxt_respGrant;
      respCause_ff <= nxt_respCause;
      respAddr_ff <= nxt_respAddr;
      respData_ff <= nxt_respData;
      respDie_ff <= nxt_respDie;
      respSegment_ff <= nxt_respSegment;
      wel_ff <= nxt_wel;
      protectCode_ff <= nxt_protectCode;
      topBottom_ff <= nxt_topBottom;
      grantCnt_ff <= nxt_grantCnt;
      refuseCnt_ff <= nxt_refuseCnt;
    end
  end

  // lock-down only ever sets, so only reset releases it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lockBits_ff <= '0;
      downBits_ff <= '0;
    end else if (lockWrEn) begin
      lockBits_ff[sector] <= cmdData[0];
      downBits_ff[sector] <= downBits_ff[sector] | cmdData[1];
    end
  end

  // apb slave, answers in the first access cycle
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic nxt_quad;
  logic [10:0] nxt_viewSector;
  always_comb begin
    nxt_pready = psel && !penable;
    nxt_pslverr = 1'b0;
    nxt_prdata = 32'h0000_0000;
    nxt_quad = quad_ff;
    nxt_viewSector = viewSector_ff;
    if (psel && !penable) begin
      unique case (paddr)
        `FWP_OFS_CTRL: begin
          nxt_prdata[`FWP_CTRL_QUAD] = quad_ff;
          nxt_prdata[`FWP_CTRL_VIEW_LSB +: 11] = viewSector_ff;
        end
        `FWP_OFS_STATUS: nxt_prdata[8:0] =
          {pinFreeze, !wpSync2_ff, topBottom_ff, protectCode_ff, wel_ff, porBusy};
        `FWP_OFS_LOCKVIEW: nxt_prdata[1:0] =
          {downBits_ff[viewSector_ff], lockBits_ff[viewSector_ff]};
        `FWP_OFS_COUNT: nxt_prdata = {refuseCnt_ff, grantCnt_ff};
        default: nxt_pslverr = 1'b1;
      endcase
    end
    if (psel && penable && pready_ff && pwrite && paddr == `FWP_OFS_CTRL) begin
      nxt_quad = pwdata[`FWP_CTRL_QUAD];
      nxt_viewSector = pwdata[`FWP_CTRL_VIEW_LSB +: 11];
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      quad_ff <= 1'b0;
      viewSector_ff <= 11'h000;
    end else begin
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      quad_ff <= nxt_quad;
      viewSector_ff <= nxt_viewSector;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign respValid = respValid_ff;
  assign respGrant = respGrant_ff;
  assign respCause = respCause_ff;
  assign respAddr = respAddr_ff;
  assign respData = respData_ff;
  assign respDie = respDie_ff;
  assign respSegment = respSegment_ff;

  a_wel_required: assert property (@(posedge clk) disable iff (sys_rst)
    cmdValid && isModifying(cmdKind) && !wel_ff |=> respValid_ff && !respGrant_ff)
    else $error("modifying command granted with latch clear");
  a_clock_count: assert property (@(posedge clk) disable iff (sys_rst)
    cmdValid && isModifying(cmdKind) && cmdClkCount[2:0] != 3'h0
    |=> !respGrant_ff && respCause_ff != CAUSE_NONE)
    else $error("bad clock count accepted");
  a_por_block: assert property (@(posedge clk) disable iff (sys_rst)
    cmdValid && porBusy |=> !respGrant_ff)
    else $error("grant during power-on hold");
  a_lock_refuse: assert property (@(posedge clk) disable iff (sys_rst)
    cmdValid && cmdKind == KIND_PROGRAM && lockBits_ff[sector] |=> !respGrant_ff)
    else $error("program granted on locked sector");
  a_lockdown_frozen: assert property (@(posedge clk) disable iff (sys_rst)
    cmdValid && cmdKind == KIND_LOCK_WRITE && downBits_ff[sector]
    |=> lockBits_ff == $past(lockBits_ff)
    ##1 lockBits_ff[$past(sector, 2)] == $past(lockBits_ff[sector], 2))
    else $error("lock bits changed under lock-down");
  a_one_way_bits: assert property (@(posedge clk) disable iff (sys_rst)
    cmdValid && cmdKind == KIND_PROGRAM |=> (respData_ff & ~$past(oldData)) == 8'h00)
    else $error("program sets a bit");
  a_top_half: assert property (@(posedge clk) disable iff (sys_rst)
    protectCode_ff == 4'hB && !topBottom_ff |-> protLo == 11'h400 && protHi == 11'h7FF)
    else $error("top range for code 11 wrong");
  a_bottom_range: assert property (@(posedge clk) disable iff (sys_rst)
    protectCode_ff == 4'h9 && topBottom_ff |-> protLo == 11'h000 && protHi == 11'h0FF)
    else $error("bottom range for code 9 wrong");
  a_subsector_base: assert property (@(posedge clk) disable iff (sys_rst)
    cmdValid && cmdKind == KIND_ERASE_SUB
    |=> respAddr_ff[11:0] == 12'h000 && respAddr_ff[26:12] == $past(cmdAddr[26:12]))
    else $error("subsector base wrong");
  a_range_refuse: assert property (@(posedge clk) disable iff (sys_rst)
    cmdValid && cmdKind == KIND_ERASE_SECT && inRange |=> !respGrant_ff)
    else $error("erase granted in protected range");
endmodule

// [design/fwp_map.svh]
// constants and offsets for the flash write protection checker
//
// Overview of operation
// - programming only clears bits; new data is old data ANDed with program data
// - erase is granted per subsector, sector or whole 256Mb die; never per page
// - 2048 sectors of 64KB, 32768 subsectors of 4KB, pages of 256 bytes
// - a page program touches only its own page, independent of neighbours
// - each die splits into two 128Mb segments, reported with every grant
// - the 64-byte OTP area skips sector lock and protect range checks
// - modifying commands need a serial clock count that is a multiple of eight
// - modifying commands need the write enable latch set beforehand
// - power-on reset and its hold timer block all data changes
// - a set sector write-lock bit refuses program and erase to that sector
// - a set lock-down bit freezes the sector's write-lock until reset
// - lock bits change only via lock-write command, ignored when locked down
// - top/bottom 0, code n in 1..11 protects top 2^(n-1) sectors; 12..15 all
// - top/bottom 1, code n in 1..11 protects sectors 0 to 2^(n-1)-1
// - protect pin low outside quad mode freezes the protect code and range
`ifndef FWP_MAP_SVH
`define FWP_MAP_SVH

`define FWP_OFS_CTRL 8'h00
`define FWP_OFS_STATUS 8'h04
`define FWP_OFS_LOCKVIEW 8'h08
`define FWP_OFS_COUNT 8'h0C

`define FWP_CTRL_QUAD 0
`define FWP_CTRL_VIEW_LSB 8
`define FWP_CTRL_RESET 32'h0000_0000

`define FWP_SECTOR_COUNT 12'h800
`define FWP_SECTORS_PER_DIE 9
`define FWP_CODE_ALL 4'hC
`define FWP_CODE_NONE 4'h0

`define FWP_CLK_MHZ 40
`define FWP_POR_HOLD_NS 1000
`define FWP_POR_CYCLES ((`FWP_POR_HOLD_NS * `FWP_CLK_MHZ + 999) / 1000)

`endif

// [design/fwp_pkg.sv]
// types shared by the flash write protection checker
package fwp_pkg;
  typedef enum logic [3:0] {
    KIND_WREN,
    KIND_WRDI,
    KIND_PROGRAM,
    KIND_ERASE_SUB,
    KIND_ERASE_SECT,
    KIND_ERASE_DIE,
    KIND_OTP_PROG,
    KIND_LOCK_WRITE,
    KIND_STATUS_WRITE
  } cmd_kind_t;

  typedef enum logic [2:0] {
    CAUSE_NONE,
    CAUSE_POR,
    CAUSE_CLKCNT,
    CAUSE_WEL,
    CAUSE_LOCK,
    CAUSE_RANGE,
    CAUSE_LOCKDOWN,
    CAUSE_PIN
  } cause_t;

  typedef enum {POR_HOLD, POR_DONE} por_state_t;
endpackage

// [design/protect_range_decode.sv]
// decodes the protect code and top/bottom bit into a sector range
`timescale 1ns/100ps
`include "fwp_map.svh"
module protect_range_decode import fwp_pkg::*; (
  input wire logic [3:0] protectCode,
  input wire logic topBottom,
  output logic anyProt,
  output logic [10:0] protLo,
  output logic [10:0] protHi
);
  logic [11:0] span;
  logic [11:0] lowEdge;
  logic [11:0] highEdge;

  always_comb begin
    span = 12'h001 << (protectCode - 4'h1);
    lowEdge = `FWP_SECTOR_COUNT - span;
    highEdge = span - 12'h001;
    anyProt = 1'b1;
    protLo = 11'h000;
    protHi = 11'h7FF;
    if (protectCode == `FWP_CODE_NONE) begin
      anyProt = 1'b0;
      protHi = 11'h000;
    end else if (protectCode >= `FWP_CODE_ALL) begin
      protLo = 11'h000;
    end else if (!topBottom) begin
      protLo = lowEdge[10:0];
    end else begin
      protHi = highEdge[10:0];
    end
  end
endmodule
